// ==== rtl/desau_pkg.sv ====
/*
 Constants, field layouts and types shared by the digit conversion unit.
 Assumes a 16-bit data memory word and 4-bit hexadecimal digits.
*/
package desau_pkg;
   typedef enum logic [1:0] {DESAU_OP_ENC, DESAU_OP_SEG, DESAU_OP_CHR} desau_op_type;

   localparam int WORD_W = 16;
   localparam int DIGIT_W = 4;
   localparam int BYTE_W = 8;

   // Register port map
   localparam int REG_AW = 2;
   localparam logic [1:0] REG_STATUS = 2'h0;
   localparam logic [1:0] REG_CLEAR = 2'h1;
   localparam logic [1:0] REG_ENABLE = 2'h2;
   localparam int STAT_W = 2;
   localparam int STAT_DONE = 0;
   localparam int STAT_ERR = 1;

   // Designator fields
   localparam int DI_FIRST_LSB = 0;
   localparam int DI_CNT_LSB = 4;
   localparam int DI_MODE_LSB = 8;
   localparam int DI_TOP_LSB = 12;
   localparam int DI_HALF_BIT = 8;
   localparam int DI_PAR_LSB = 9;
   localparam logic [3:0] DI_DIGIT_MAX = 4'h3;
   localparam logic [3:0] DI_SEG_MODE_MAX = 4'h1;
   localparam logic [3:0] DI_CHR_MODE_MAX = 4'h5;
   localparam logic [3:0] DI_ZERO = 4'h0;

   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;

   // Segment patterns, digit F in the top byte down to digit 0 in the bottom
   localparam logic [127:0] SEG_LUT = 128'h71795E397C776F7F277D6D664F5B063F;
   localparam logic [7:0] SEG_EIGHT = 8'h7F;
   localparam logic [3:0] DIGIT_EIGHT = 4'h8;

   localparam logic [3:0] ASC_DEC_MAX = 4'h9;
   localparam logic [7:0] ASC_NUM_BASE = 8'h30;
   localparam logic [7:0] ASC_ALPHA_BASE = 8'h37;
endpackage

// ==== rtl/desau_unit.sv ====
/*
 Digit conversion unit: priority encoder, 7-segment decoder and character
 converter with parity. Assumes a data memory that returns read data the
 cycle after its read strobe and a sequencer that supplies area limits and
 an indirect-operand fault flag with each command.
*/
// Function
// - Execution condition false: no conversion, no destination word changes.
// - Encoder writes highest set bit number of a source word as one digit.
// - Up to four source words fill digits in order, wrapping past digit three.
// - Encoder designator low two digits must be 0 to 3, else error.
// - Encoder flags an error for any zero source word.
// - Encoder flags an error when the last source word leaves its area.
// - Any bad indirect operand flags an error.
// - Segment decoder turns each chosen digit into an 8-bit pattern.
// - Designator gives first digit, count and starting byte half; halves follow.
// - Segment and character digits wrap to digit zero of the source.
// - Segments g..a in bits 6..0, bit 7 zero, fixed hex table.
// - Segment and character flag invalid designators and destination overrun.
// - Character converter turns each chosen digit into an 8-bit code.
// - Character codes fill successive byte halves from the chosen half.
// - No parity: top bit of every code is zero.
// - Even parity: top bit makes the byte's one count even.
// - Odd parity: top bit makes the byte's one count odd.
`timescale 1ns/100ps
module desau_unit #(
   parameter int ADDR_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmdValid,
   input wire desau_pkg::desau_op_type cmdOp,
   input wire logic execCond,
   input wire logic opndFault,
   input wire logic [ADDR_W-1:0] srcAddr,
   input wire logic [ADDR_W-1:0] dstAddr,
   input wire logic [desau_pkg::WORD_W-1:0] digitDesignator,
   input wire logic [ADDR_W-1:0] srcAreaEnd,
   input wire logic [ADDR_W-1:0] dstAreaEnd,
   output logic busy,
   output logic done,
   output logic errorFlag,
   output logic [ADDR_W-1:0] memAddr,
   output logic memRd,
   output logic memWr,
   output logic [desau_pkg::WORD_W-1:0] memWdata,
   input wire logic [desau_pkg::WORD_W-1:0] memRdata,
   input wire logic [desau_pkg::REG_AW-1:0] regAddr,
   input wire logic [desau_pkg::WORD_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [desau_pkg::WORD_W-1:0] regRdata,
   output logic irq
);
   if (ADDR_W < 4) begin : g_chk
      $error("ADDR_W too small");
   end

   typedef enum logic [2:0] {
      ST_IDLE, ST_CHECK, ST_WSRC, ST_WDST, ST_FILL, ST_WRITE, ST_NEXT
   } desau_state_type;

   desau_state_type state_r;
   desau_pkg::desau_op_type op_r;
   logic [desau_pkg::WORD_W-1:0] di_r;
   logic [ADDR_W-1:0] sAddr_r;
   logic [ADDR_W-1:0] dAddr_r;
   logic [ADDR_W-1:0] sEnd_r;
   logic [ADDR_W-1:0] dEnd_r;
   logic fault_r;
   logic [1:0] idx_r;
   logic half_r;
   logic last_r;
   logic [desau_pkg::WORD_W-1:0] buf_r;
   logic [desau_pkg::WORD_W-1:0] srcWord_r;
   logic busy_r;
   logic done_r;
   logic errorFlag_r;
   logic [ADDR_W-1:0] memAddr_r;
   logic memRd_r;
   logic memWr_r;
   logic [desau_pkg::WORD_W-1:0] memWdata_r;
   logic [desau_pkg::STAT_W-1:0] status_r;
   logic [desau_pkg::STAT_W-1:0] enable_r;
   logic [desau_pkg::WORD_W-1:0] regRdata_r;
   logic irq_r;

   assign busy = busy_r;
   assign done = done_r;
   assign errorFlag = errorFlag_r;
   assign memAddr = memAddr_r;
   assign memRd = memRd_r;
   assign memWr = memWr_r;
   assign memWdata = memWdata_r;
   assign regRdata = regRdata_r;
   assign irq = irq_r;

   // Highest set bit number; zero words are trapped before use
   function automatic logic [3:0] priEnc(input logic [desau_pkg::WORD_W-1:0] w);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < desau_pkg::WORD_W; i++) begin
         if (w[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   logic [3:0] diFirst;
   logic [3:0] diCnt;
   logic [3:0] diMode;
   logic [3:0] diTop;
   logic [1:0] cntM1;
   logic [1:0] digIdx;
   logic [3:0] srcDigit;
   logic [1:0] parMode;
   logic [7:0] chrCode;
   logic [7:0] outByte;
   logic [2:0] lastByte;
   logic [ADDR_W:0] srcLast;
   logic [ADDR_W:0] dstLast;
   logic diBad;
   logic areaBad;
   logic chkErr;

   always_comb begin
      diFirst = di_r[desau_pkg::DI_FIRST_LSB +: 4];
      diCnt = di_r[desau_pkg::DI_CNT_LSB +: 4];
      diMode = di_r[desau_pkg::DI_MODE_LSB +: 4];
      diTop = di_r[desau_pkg::DI_TOP_LSB +: 4];
      cntM1 = diCnt[1:0];
      parMode = di_r[desau_pkg::DI_PAR_LSB +: 2];
      digIdx = diFirst[1:0] + idx_r;
      srcDigit = srcWord_r[{digIdx, 2'b00} +: desau_pkg::DIGIT_W];
      diBad = (diFirst > desau_pkg::DI_DIGIT_MAX) || (diCnt > desau_pkg::DI_DIGIT_MAX)
              || (diTop != desau_pkg::DI_ZERO);
      unique case (op_r)
         desau_pkg::DESAU_OP_ENC: diBad = diBad || (diMode != desau_pkg::DI_ZERO);
         desau_pkg::DESAU_OP_SEG: diBad = diBad || (diMode > desau_pkg::DI_SEG_MODE_MAX);
         default: diBad = diBad || (diMode > desau_pkg::DI_CHR_MODE_MAX);
      endcase
      lastByte = {2'b00, di_r[desau_pkg::DI_HALF_BIT]} + {1'b0, cntM1};
      srcLast = {1'b0, sAddr_r} + {{(ADDR_W-1){1'b0}}, cntM1};
      dstLast = {1'b0, dAddr_r} + {{(ADDR_W-1){1'b0}}, lastByte[2:1]};
      areaBad = (sAddr_r > sEnd_r) || (dAddr_r > dEnd_r);
      if (op_r == desau_pkg::DESAU_OP_ENC) begin
         areaBad = areaBad || (srcLast > {1'b0, sEnd_r});
      end else begin
         areaBad = areaBad || (dstLast > {1'b0, dEnd_r});
      end
      chkErr = fault_r || diBad || areaBad;
      chrCode = ((srcDigit > desau_pkg::ASC_DEC_MAX) ? desau_pkg::ASC_ALPHA_BASE
                 : desau_pkg::ASC_NUM_BASE) + {4'h0, srcDigit};
      if (op_r == desau_pkg::DESAU_OP_SEG) begin
         outByte = desau_pkg::SEG_LUT[{srcDigit, 3'b000} +: desau_pkg::BYTE_W];
      end else begin
         unique case (parMode)
            desau_pkg::PAR_EVEN: outByte = {^chrCode[6:0], chrCode[6:0]};
            desau_pkg::PAR_ODD: outByte = {~^chrCode[6:0], chrCode[6:0]};
            default: outByte = {1'b0, chrCode[6:0]};
         endcase
      end
   end

   // Sequencer and memory port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         op_r <= desau_pkg::DESAU_OP_ENC;
         di_r <= '0;
         sAddr_r <= '0;
         dAddr_r <= '0;
         sEnd_r <= '0;
         dEnd_r <= '0;
         fault_r <= 1'b0;
         idx_r <= 2'h0;
         half_r <= 1'b0;
         last_r <= 1'b0;
         buf_r <= '0;
         srcWord_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         errorFlag_r <= 1'b0;
         memAddr_r <= '0;
         memRd_r <= 1'b0;
         memWr_r <= 1'b0;
         memWdata_r <= '0;
      end else begin
         memRd_r <= 1'b0;
         memWr_r <= 1'b0;
         done_r <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               if (cmdValid) begin
                  if (!execCond) begin
                     done_r <= 1'b1;
                     errorFlag_r <= 1'b0;
                  end else begin
                     op_r <= cmdOp;
                     di_r <= digitDesignator;
                     sAddr_r <= srcAddr;
                     dAddr_r <= dstAddr;
                     sEnd_r <= srcAreaEnd;
                     dEnd_r <= dstAreaEnd;
                     fault_r <= opndFault;
                     busy_r <= 1'b1;
                     state_r <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               idx_r <= 2'h0;
               half_r <= di_r[desau_pkg::DI_HALF_BIT];
               last_r <= 1'b0;
               if (chkErr) begin
                  done_r <= 1'b1;
                  errorFlag_r <= 1'b1;
                  busy_r <= 1'b0;
                  state_r <= ST_IDLE;
               end else begin
                  memRd_r <= 1'b1;
                  if (op_r == desau_pkg::DESAU_OP_ENC) begin
                     memAddr_r <= dAddr_r;
                     state_r <= ST_WDST;
                  end else begin
                     memAddr_r <= sAddr_r;
                     state_r <= ST_WSRC;
                  end
               end
            end
            ST_WSRC: begin
               if (!memRd_r) begin
                  if (op_r != desau_pkg::DESAU_OP_ENC) begin
                     srcWord_r <= memRdata;
                     memRd_r <= 1'b1;
                     memAddr_r <= dAddr_r;
                     state_r <= ST_WDST;
                  end else if (memRdata == '0) begin
                     done_r <= 1'b1;
                     errorFlag_r <= 1'b1;
                     busy_r <= 1'b0;
                     state_r <= ST_IDLE;
                  end else begin
                     buf_r[{digIdx, 2'b00} +: desau_pkg::DIGIT_W] <= priEnc(memRdata);
                     if (idx_r == cntM1) begin
                        state_r <= ST_WRITE;
                     end else begin
                        idx_r <= idx_r + 2'h1;
                        memRd_r <= 1'b1;
                        memAddr_r <= memAddr_r + 1'b1;
                     end
                  end
               end
            end
            ST_WDST: begin
               if (!memRd_r) begin
                  buf_r <= memRdata;
                  if (op_r == desau_pkg::DESAU_OP_ENC) begin
                     memRd_r <= 1'b1;
                     memAddr_r <= sAddr_r;
                     state_r <= ST_WSRC;
                  end else begin
                     state_r <= ST_FILL;
                  end
               end
            end
            ST_FILL: begin
               buf_r[{half_r, 3'b000} +: desau_pkg::BYTE_W] <= outByte;
               idx_r <= idx_r + 2'h1;
               half_r <= ~half_r;
               if (idx_r == cntM1) begin
                  last_r <= 1'b1;
                  state_r <= ST_WRITE;
               end else if (half_r) begin
                  state_r <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               memWr_r <= 1'b1;
               memAddr_r <= dAddr_r;
               memWdata_r <= buf_r;
               if (op_r == desau_pkg::DESAU_OP_ENC || last_r) begin
                  done_r <= 1'b1;
                  errorFlag_r <= 1'b0;
                  busy_r <= 1'b0;
                  state_r <= ST_IDLE;
               end else begin
                  dAddr_r <= dAddr_r + 1'b1;
                  state_r <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               memRd_r <= 1'b1;
               memAddr_r <= dAddr_r;
               state_r <= ST_WDST;
            end
         endcase
      end
   end

   // Register port and interrupt
   logic [desau_pkg::STAT_W-1:0] evt;
   assign evt = {done_r & errorFlag_r, done_r};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= '0;
         enable_r <= '0;
         regRdata_r <= '0;
         irq_r <= 1'b0;
      end else begin
         if (regWr && regAddr == desau_pkg::REG_CLEAR) begin
            status_r <= (status_r & ~regWdata[desau_pkg::STAT_W-1:0]) | evt;
         end else begin
            status_r <= status_r | evt;
         end
         if (regWr && regAddr == desau_pkg::REG_ENABLE) begin
            enable_r <= regWdata[desau_pkg::STAT_W-1:0];
         end
         regRdata_r <= '0;
         if (regRd) begin
            unique case (regAddr)
               desau_pkg::REG_STATUS: regRdata_r <= {{(desau_pkg::WORD_W-2){1'b0}}, status_r};
               desau_pkg::REG_ENABLE: regRdata_r <= {{(desau_pkg::WORD_W-2){1'b0}}, enable_r};
               default: regRdata_r <= '0;
            endcase
         end
         irq_r <= |(status_r & enable_r);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_errEnd;
      ##1 (done_r && errorFlag_r && !memWr_r);
   endsequence

   property p_skip;
      (state_r == ST_IDLE && cmdValid && !execCond) |=> done_r && !errorFlag_r && !busy_r
         ##1 !memWr_r;
   endproperty
   a_skip: assert property (p_skip) else $error("skipped op changed state");

   property p_enc;
      (state_r == ST_WSRC && !memRd_r && op_r == desau_pkg::DESAU_OP_ENC && memRdata != '0)
         |-> memRdata[priEnc(memRdata)] && ((memRdata >> priEnc(memRdata)) == 16'h0001);
   endproperty
   a_enc: assert property (p_enc) else $error("wrong highest bit");

   property p_badDi;
      (state_r == ST_IDLE && cmdValid && execCond
         && digitDesignator[desau_pkg::DI_FIRST_LSB +: 4] > desau_pkg::DI_DIGIT_MAX)
         |-> ##1 s_errEnd;
   endproperty
   a_badDi: assert property (p_badDi) else $error("bad designator not flagged");

   property p_zero;
      (state_r == ST_WSRC && !memRd_r && op_r == desau_pkg::DESAU_OP_ENC && memRdata == '0)
         |-> s_errEnd;
   endproperty
   a_zero: assert property (p_zero) else $error("zero source not flagged");

   property p_fault;
      (state_r == ST_CHECK && (fault_r || areaBad)) |-> s_errEnd;
   endproperty
   a_fault: assert property (p_fault) else $error("operand fault not flagged");

   property p_seg8;
      (state_r == ST_FILL && op_r == desau_pkg::DESAU_OP_SEG
         && srcDigit == desau_pkg::DIGIT_EIGHT)
         |=> $past(half_r) ? buf_r[15:8] == desau_pkg::SEG_EIGHT
         : buf_r[7:0] == desau_pkg::SEG_EIGHT;
   endproperty
   a_seg8: assert property (p_seg8) else $error("segment code wrong");

   property p_par(logic [1:0] m, logic want);
      (state_r == ST_FILL && op_r == desau_pkg::DESAU_OP_CHR && parMode == m)
         |=> ($past(half_r) ? ^buf_r[15:8] : ^buf_r[7:0]) == want;
   endproperty
   a_parEven: assert property (p_par(desau_pkg::PAR_EVEN, 1'b0)) else $error("even parity");
   a_parOdd: assert property (p_par(desau_pkg::PAR_ODD, 1'b1)) else $error("odd parity");

   property p_noPar;
      (state_r == ST_FILL && op_r == desau_pkg::DESAU_OP_CHR && parMode == desau_pkg::PAR_NONE)
         |=> !($past(half_r) ? buf_r[15] : buf_r[7]);
   endproperty
   a_noPar: assert property (p_noPar) else $error("top bit not zero");
endmodule

// ==== tb/desau_mem_model.sv ====
/*
 Data memory model for the digit conversion unit bench.
 Assumes read data are wanted only in the cycle after the read strobe.
*/
`timescale 1ns/100ps
module desau_mem_model #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic memRd,
   input wire logic memWr,
   input wire logic [desau_pkg::WORD_W-1:0] memWdata,
   output logic [desau_pkg::WORD_W-1:0] memRdata
);
   logic [desau_pkg::WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [desau_pkg::WORD_W-1:0] rdWord_r = 16'h0000;
   logic rdValid_r = 1'b0;
   // Plain always: the bench preloads mem by hierarchical assignment between commands
   always @(posedge clk) begin
      rdValid_r <= memRd;
      if (memRd) begin
         rdWord_r <= mem[memAddr];
      end
      if (memWr) begin
         mem[memAddr] <= memWdata;
      end
   end
   // Outside the answer cycle show the inverse so stale data never passes
   assign memRdata = rdValid_r ? rdWord_r : ~rdWord_r;
endmodule

// ==== tb/tb_top.sv ====
/*
 Self-checking bench of the digit conversion unit with a memory model.
 Assumes the unit's hand-over timing: one command at a time, done pulse.
*/
`timescale 1ns/100ps
module tb_top;
   localparam int AW = 8;
   localparam logic [7:0] SEGTAB [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D,
      8'h27, 8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmdValid = 1'b0;
   desau_pkg::desau_op_type cmdOp = desau_pkg::DESAU_OP_ENC;
   logic execCond = 1'b0;
   logic opndFault = 1'b0;
   logic [AW-1:0] srcAddr = 8'h00;
   logic [AW-1:0] dstAddr = 8'h00;
   logic [15:0] digitDesignator = 16'h0000;
   logic [AW-1:0] srcAreaEnd = 8'h00;
   logic [AW-1:0] dstAreaEnd = 8'h00;
   logic [1:0] regAddr = 2'h0;
   logic [15:0] regWdata = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic busy, done, errorFlag, memRd, memWr, irq;
   logic [AW-1:0] memAddr;
   logic [15:0] memWdata, memRdata, regRdata, rd;
   logic [15:0] expMem [0:31];
   int err_total = 0;
   int checks = 0;
   int seed = 84;
   int cycles = 0;
   int wrCount = 0;
   int r;

   always #2.5 clk = ~clk;

   desau_unit #(.ADDR_W(AW)) i_desau_unit (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
      .cmdOp(cmdOp), .execCond(execCond), .opndFault(opndFault), .srcAddr(srcAddr),
      .dstAddr(dstAddr), .digitDesignator(digitDesignator), .srcAreaEnd(srcAreaEnd),
      .dstAreaEnd(dstAreaEnd), .busy(busy), .done(done), .errorFlag(errorFlag),
      .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWdata(memWdata),
      .memRdata(memRdata), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .irq(irq));
   desau_mem_model #(.ADDR_W(AW)) i_desau_mem_model (.clk(clk), .memAddr(memAddr),
      .memRd(memRd), .memWr(memWr), .memWdata(memWdata), .memRdata(memRdata));

   always @(posedge clk) begin
      cycles++;
      if (memWr === 1'b1) begin
         wrCount++;
      end
      if (cycles >= 20000) begin
         err_total++;
         $display("timeout after %0d cycles", cycles);
         end_of_test;
      end
   end

   task automatic chk_bit(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask

   task automatic fill_mem;
      for (int i = 0; i < 32; i++) begin
         expMem[i] = 16'($random(seed));
         i_desau_mem_model.mem[i] = expMem[i];
      end
   endtask

   function automatic logic [7:0] chr_code(input logic [3:0] d, input int par);
      logic [7:0] c;
      c = (d <= 4'h9) ? 8'h30 + 8'(d) : 8'h37 + 8'(d);
      if (par == 1) begin
         c[7] = ^c[6:0];
      end else if (par == 2) begin
         c[7] = ~^c[6:0];
      end
      return c;
   endfunction

   // Returns the expected error and applies the expected writes to expMem
   function automatic logic predict(input int op, input logic [15:0] di, input int src,
      input int dst, input int sEnd, input int dEnd);
      int first, cnt, md, pos, h;
      logic [15:0] w;
      first = di[3:0];
      cnt = di[7:4] + 1;
      md = di[11:8];
      if (di[3:0] > 3 || di[7:4] > 3 || di[15:12] != 0 || src > sEnd || dst > dEnd) return 1'b1;
      if (op == 0) begin
         if (md != 0 || src + cnt - 1 > sEnd) return 1'b1;
         w = expMem[dst];
         for (int i = 0; i < cnt; i++) begin
            if (expMem[src + i] == 16'h0000) return 1'b1;
            for (int b = 0; b < 16; b++) begin
               if (expMem[src + i][b]) h = b;
            end
            w[4 * ((first + i) % 4) +: 4] = 4'(h);
         end
         expMem[dst] = w;
         return 1'b0;
      end
      if (md > ((op == 1) ? 1 : 5) || dst + (di[8] + cnt - 1) / 2 > dEnd) return 1'b1;
      for (int i = 0; i < cnt; i++) begin
         w[3:0] = expMem[src][4 * ((first + i) % 4) +: 4];
         pos = di[8] + i;
         expMem[dst + pos / 2][8 * (pos % 2) +: 8] =
            (op == 1) ? SEGTAB[w[3:0]] : chr_code(w[3:0], di[10:9]);
      end
      return 1'b0;
   endfunction

   task automatic do_cmd(input string name, input int op, input logic ec, input logic flt,
      input logic [15:0] di, input int src, input int dst, input int sEnd, input int dEnd);
      logic expErr;
      int w0;
      int n;
      w0 = wrCount;
      expErr = 1'b0;
      if (ec && flt) expErr = 1'b1;
      else if (ec) expErr = predict(op, di, src, dst, sEnd, dEnd);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdOp <= desau_pkg::desau_op_type'(op);
      execCond <= ec;
      opndFault <= flt;
      digitDesignator <= di;
      srcAddr <= AW'(src);
      dstAddr <= AW'(dst);
      srcAreaEnd <= AW'(sEnd);
      dstAreaEnd <= AW'(dEnd);
      @(posedge clk);
      cmdValid <= 1'b0;
      #1;
      chk_bit({name, " busy"}, ec, busy);
      n = 0;
      while (done !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_bit({name, " done"}, 1'b1, done);
      chk_bit({name, " error"}, expErr, errorFlag);
      @(posedge clk);
      #1;
      if (!ec || expErr) chk_bit({name, " no write"}, 1'b1, wrCount == w0);
      for (int i = 0; i < 32; i++) begin
         chk_word($sformatf("%s word %0d", name, i), expMem[i], i_desau_mem_model.mem[i]);
      end
      $display("test %s done", name);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      fill_mem;
      reg_read(desau_pkg::REG_STATUS, rd);
      chk_word("status at reset", 16'h0000, rd);
      reg_read(desau_pkg::REG_ENABLE, rd);
      chk_word("enable at reset", 16'h0000, rd);
      for (int op = 0; op < 3; op++) begin
         do_cmd("skipped", op, 1'b0, 1'b0, 16'h0030, 0, 16, 31, 31);
      end
      do_cmd("enc wrap", 0, 1'b1, 1'b0, 16'h0033, 0, 16, 31, 31);
      do_cmd("enc area edge", 0, 1'b1, 1'b0, 16'h0020, 2, 17, 4, 31);
      do_cmd("enc area over", 0, 1'b1, 1'b0, 16'h0020, 2, 17, 3, 31);
      do_cmd("enc bad digit", 0, 1'b1, 1'b0, 16'h0004, 0, 16, 31, 31);
      do_cmd("enc bad count", 0, 1'b1, 1'b0, 16'h0040, 0, 16, 31, 31);
      expMem[1] = 16'h0000;
      i_desau_mem_model.mem[1] = 16'h0000;
      do_cmd("enc zero", 0, 1'b1, 1'b0, 16'h0010, 0, 16, 31, 31);
      for (int op = 0; op < 3; op++) begin
         do_cmd("fault", op, 1'b1, 1'b1, 16'h0000, 2, 16, 31, 31);
      end
      for (int k = 0; k < 4; k++) begin
         expMem[4] = 16'h3210 + 16'h4444 * 16'(k);
         i_desau_mem_model.mem[4] = expMem[4];
         do_cmd("seg table", 1, 1'b1, 1'b0, {8'h01, 4'h3, 4'(k)}, 4, 16, 31, 31);
         for (int p = 0; p < 3; p++) begin
            do_cmd("chr parity", 2, 1'b1, 1'b0, {4'h0, 4'(2 * p + k % 2), 4'h3, 4'(k)},
               4, 18, 31, 31);
         end
      end
      do_cmd("seg bad mode", 1, 1'b1, 1'b0, 16'h0200, 4, 16, 31, 31);
      do_cmd("chr bad mode", 2, 1'b1, 1'b0, 16'h0600, 4, 16, 31, 31);
      do_cmd("seg dst over", 1, 1'b1, 1'b0, 16'h0130, 4, 16, 31, 17);
      do_cmd("chr dst over", 2, 1'b1, 1'b0, 16'h0130, 4, 16, 31, 17);
      for (int t = 0; t < 30; t++) begin
         fill_mem;
         r = $random(seed) & 32'h7FFF_FFFF;
         do_cmd("random", r % 3, (r % 7) != 0, 1'b0, {4'h0, 4'((r / 3) % ((r % 3 == 0) ? 1 : 6)),
            4'(r / 20), 4'(r / 80 % 5)}, r / 400 % 8, 16 + r / 5000 % 3, 3 + r / 9 % 10,
            17 + r / 13 % 4);
      end
      reg_write(desau_pkg::REG_CLEAR, 16'h0003);
      reg_write(desau_pkg::REG_ENABLE, 16'h0002);
      do_cmd("irq source", 0, 1'b1, 1'b0, 16'h0004, 0, 16, 31, 31);
      repeat (2) @(posedge clk);
      #1;
      chk_bit("irq raised", 1'b1, irq);
      reg_read(desau_pkg::REG_STATUS, rd);
      chk_word("status events", 16'h0003, rd);
      reg_write(desau_pkg::REG_STATUS, 16'h0000);
      reg_write(desau_pkg::REG_CLEAR, 16'h0001);
      reg_read(desau_pkg::REG_STATUS, rd);
      chk_word("status partly cleared", 16'h0002, rd);
      reg_write(desau_pkg::REG_ENABLE, 16'h0001);
      repeat (2) @(posedge clk);
      #1;
      chk_bit("irq masked", 1'b0, irq);
      reg_write(desau_pkg::REG_CLEAR, 16'h0002);
      reg_read(desau_pkg::REG_CLEAR, rd);
      chk_word("clear reads zero", 16'h0000, rd);
      reg_read(2'h3, rd);
      chk_word("unmapped reads zero", 16'h0000, rd);
      reg_read(desau_pkg::REG_STATUS, rd);
      chk_word("status cleared", 16'h0000, rd);
      end_of_test;
   end
endmodule
